// *** frt_pkg.sv ***
// Package: register map, field layout and constants of the free-running capture timer
package frt_pkg;
  // ===========================================
  // Register byte offsets (Wishbone, 32-bit words)
  // Six address bits so the last capture word at 0x20 stays reachable
  localparam logic [5:0] COUNT_OFS = 6'h00;
  localparam logic [5:0] CTRL_OFS = 6'h04;
  localparam logic [5:0] EDGE_OFS = 6'h08;
  localparam logic [5:0] STAT_OFS = 6'h0c;
  localparam logic [5:0] MASK_OFS = 6'h10;
  localparam logic [5:0] CAPT_OFS = 6'h14;
  localparam int CAPT_ADDR_BITS = 6;
  // ===========================================
  // Control status fields
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_EXT_BIT = 3;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_CLR_BIT = 5;
  localparam int CTRL_OVF_BIT = 6;
  localparam int CTRL_OVIE_BIT = 7;
  localparam logic [2:0] DIV_RESET = 3'h0;
  // ===========================================
  // Status bits: bit 0 overflow, bits 1..4 capture channels
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CAP_LSB = 1;
  localparam int NUM_CH = 4;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
  // ===========================================
  // Capture edge selection, two bits per channel
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_e;
  typedef struct packed {
    logic [2:0] div;
    logic ext;
    logic run;
  } tctrl_s;
  localparam logic [4:0] STAT_W1 = 5'h1f;
endpackage

// *** capture_unit.sv ***
// One capture channel: synchroniser, edge detect and capture data register
`timescale 1ns/1ps
module capture_unit
  import frt_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Pin and configuration
  input wire logic pin,
  input wire logic [1:0] edge_sel,
  input wire logic [15:0] count,
  // Result
  output logic event_p,
  output logic [15:0] data
);
  logic s1_r, s2_r, s3_r;
  logic [15:0] data_r, data_nxt;
  logic hit;

  always_comb begin
    hit = 1'b0;
    case (edge_sel)
      EDGE_RISE: hit = s2_r & ~s3_r;
      EDGE_FALL: hit = ~s2_r & s3_r;
      EDGE_BOTH: hit = s2_r ^ s3_r;
      default: hit = 1'b0;
    endcase
    data_nxt = hit ? count : data_r;
  end

  // Two stages before use; s3 only remembers the prior level
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      data_r <= COUNT_RESET;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      data_r <= data_nxt;
    end
  end

  assign event_p = hit;
  assign data = data_r;

  capture_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
    hit |=> data_r == $past(count)) else $error("capture missed count");
endmodule

// *** frt_timer.sv ***
// Top: 16-bit free-running counter with prescaler and four capture channels
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module frt_timer
  import frt_pkg::*;
#(
  parameter int NCH = NUM_CH
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [CAPT_ADDR_BITS-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Pins
  input wire logic EXT_COUNT_CLOCK_PIN,
  input wire logic [NCH-1:0] CAPTURE_PIN,
  // Interrupts
  output logic IRQ,
  output logic OVF_IRQ,
  output logic [NCH-1:0] CAP_IRQ,
  output logic IO_SERVICE_REQ
);
  // ===========================================
  // Bus decode
  logic req, wr, rd, ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic lo_en;
  assign req = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr = req & WB_WE_I;
  assign rd = req & ~WB_WE_I;
  assign lo_en = WB_SEL_I[0];

  // ===========================================
  // Control and status state
  tctrl_s ctrl_r, ctrl_nxt;
  logic ovie_r, ovie_nxt;
  logic ovf_r, ovf_nxt;
  logic [15:0] count_r, count_nxt;
  logic [2*NCH-1:0] edge_r, edge_nxt;
  logic [NCH:0] stat_r, stat_nxt;
  logic [NCH:0] mask_r, mask_nxt;
  logic [6:0] pre_r, pre_nxt;
  logic ek1_r, ek2_r, ek3_r;
  logic tick, wrap;
  logic [NCH-1:0] cap_ev;
  logic [15:0] cap_data [NCH];
  logic [3:0] ch_idx;

  // Prescaler: ratio is 2^div, div 0 means every machine clock
  always_comb begin
    pre_nxt = ctrl_r.run ? pre_r + 7'h01 : pre_r;
    tick = 1'b0;
    if (ctrl_r.ext) begin
      tick = ek2_r & ~ek3_r;
    end else if (ctrl_r.div == 3'h0) begin
      tick = 1'b1;
    end else begin
      tick = (pre_r & ((7'h01 << ctrl_r.div) - 7'h01)) == 7'h00;
    end
    tick = tick & ctrl_r.run;
  end

  assign wrap = tick && count_r == COUNT_ALL_ONES;

  // ===========================================
  // Register write side
  always_comb begin
    ctrl_nxt = ctrl_r;
    ovie_nxt = ovie_r;
    edge_nxt = edge_r;
    mask_nxt = mask_r;
    count_nxt = tick ? count_r + 16'h0001 : count_r;
    ovf_nxt = ovf_r;
    stat_nxt = stat_r;
    if (wr && lo_en) begin
      case (WB_ADR_I)
        CTRL_OFS: begin
          ctrl_nxt.div = WB_DAT_I[CTRL_DIV_LSB +: 3];
          ctrl_nxt.ext = WB_DAT_I[CTRL_EXT_BIT];
          ctrl_nxt.run = WB_DAT_I[CTRL_RUN_BIT];
          ovie_nxt = WB_DAT_I[CTRL_OVIE_BIT];
          if (!WB_DAT_I[CTRL_OVF_BIT]) begin
            ovf_nxt = 1'b0;
          end
          if (WB_DAT_I[CTRL_CLR_BIT]) begin
            count_nxt = COUNT_RESET;
          end
        end
        COUNT_OFS: begin
          if (!ctrl_r.run && WB_SEL_I[1]) begin
            count_nxt = WB_DAT_I[15:0];
          end
        end
        EDGE_OFS: edge_nxt = WB_DAT_I[2*NCH-1:0];
        STAT_OFS: stat_nxt = stat_r & ~WB_DAT_I[NCH:0];
        MASK_OFS: mask_nxt = WB_DAT_I[NCH:0];
        default: ;
      endcase
    end
    // Events win over a clear in the same cycle
    if (wrap) begin
      ovf_nxt = 1'b1;
    end
    stat_nxt[STAT_OVF_BIT] = stat_nxt[STAT_OVF_BIT] | wrap;
    stat_nxt[NCH:STAT_CAP_LSB] = stat_nxt[NCH:STAT_CAP_LSB] | cap_ev;
  end

  // ===========================================
  // Register read side
  always_comb begin
    ch_idx = 4'(WB_ADR_I[5:2] - CAPT_OFS[5:2]);
    rdata_nxt = 32'h0000_0000;
    case (WB_ADR_I)
      COUNT_OFS: rdata_nxt = {16'h0000, count_r};
      CTRL_OFS: begin
        rdata_nxt[CTRL_DIV_LSB +: 3] = ctrl_r.div;
        rdata_nxt[CTRL_EXT_BIT] = ctrl_r.ext;
        rdata_nxt[CTRL_RUN_BIT] = ctrl_r.run;
        rdata_nxt[CTRL_OVF_BIT] = ovf_r;
        rdata_nxt[CTRL_OVIE_BIT] = ovie_r;
      end
      EDGE_OFS: rdata_nxt[2*NCH-1:0] = edge_r;
      STAT_OFS: rdata_nxt[NCH:0] = stat_r;
      MASK_OFS: rdata_nxt[NCH:0] = mask_r;
      default: begin
        if (WB_ADR_I >= CAPT_OFS && int'(ch_idx) < NCH) begin
          rdata_nxt = {16'h0000, cap_data[ch_idx[1:0]]};
        end
      end
    endcase
    ack_nxt = req;
  end

  // ===========================================
  // Registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_r <= '{div: DIV_RESET, ext: 1'b0, run: 1'b0};
      ovie_r <= 1'b0;
      ovf_r <= 1'b0;
      count_r <= COUNT_RESET;
      edge_r <= '0;
      stat_r <= '0;
      mask_r <= '0;
      pre_r <= 7'h00;
      ek1_r <= 1'b0;
      ek2_r <= 1'b0;
      ek3_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      ovie_r <= ovie_nxt;
      ovf_r <= ovf_nxt;
      count_r <= count_nxt;
      edge_r <= edge_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      pre_r <= pre_nxt;
      ek1_r <= EXT_COUNT_CLOCK_PIN;
      ek2_r <= ek1_r;
      ek3_r <= ek2_r;
      ack_r <= ack_nxt;
      rdata_r <= rd ? rdata_nxt : rdata_r;
    end
  end

  // ===========================================
  // Capture channels, one unit per capture pin
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      capture_unit u_cap (
        .CLK(CLK),
        .RSTN(RSTN),
        .pin(CAPTURE_PIN[g]),
        .edge_sel(edge_r[2*g +: 2]),
        .count(count_r),
        .event_p(cap_ev[g]),
        .data(cap_data[g])
      );
    end
  endgenerate

  // ===========================================
  // Outputs
  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = rdata_r;
  assign OVF_IRQ = ovf_r & ovie_r;
  assign CAP_IRQ = stat_r[NCH:STAT_CAP_LSB] & mask_r[NCH:STAT_CAP_LSB];
  // Same request lines drive the transfer service; it arbitrates on its own
  assign IO_SERVICE_REQ = OVF_IRQ | (|CAP_IRQ);
  assign IRQ = |(stat_r & mask_r);

  // ===========================================
  // Checks
  property ovf_sticky_p;
    @(posedge CLK) disable iff (!RSTN)
      wrap |=> ovf_r ##1 ovf_r || $past(wr);
  endproperty
  overflow_flag_a: assert property (ovf_sticky_p) else $error("overflow flag lost");
  count_step_a: assert property (@(posedge CLK) disable iff (!RSTN)
    tick && !wr |=> count_r == $past(count_r) + 16'h0001) else $error("count step");
  stopped_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
    !ctrl_r.run && !wr |=> count_r == $past(count_r)) else $error("counted stopped");
  irq_level_a: assert property (@(posedge CLK) disable iff (!RSTN)
    wrap && ovie_r && !wr |=> OVF_IRQ) else $error("overflow irq");
  sw_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
    wr && lo_en && WB_ADR_I == CTRL_OFS && WB_DAT_I[CTRL_CLR_BIT]
    |=> count_r == COUNT_RESET) else $error("clear failed");
  load_write_a: assert property (@(posedge CLK) disable iff (!RSTN)
    wr && WB_ADR_I == COUNT_OFS && &WB_SEL_I[1:0] && !ctrl_r.run
    |=> count_r == $past(WB_DAT_I[15:0])) else $error("load failed");
  live_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
    rd && WB_ADR_I == COUNT_OFS |=> WB_DAT_O[15:0] == $past(count_r)) else $error("read");
  cap_sticky_a: assert property (@(posedge CLK) disable iff (!RSTN)
    cap_ev[0] |=> stat_r[STAT_CAP_LSB]) else $error("capture flag");
  ack_once_a: assert property (@(posedge CLK) disable iff (!RSTN)
    WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
  // Every taken request is answered on the very next edge
  ack_follow_a: assert property (@(posedge CLK) disable iff (!RSTN)
    req |=> WB_ACK_O) else $error("ack late");
  // Holes in the map must read as zero so software sees no stale data
  unmapped_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
    rd && int'(WB_ADR_I) >= int'(CAPT_OFS) + 4 * NCH |=> WB_DAT_O == 32'h0000_0000)
    else $error("unmapped read");
  // A divided tick never repeats on the next clock while the ratio is unchanged
  prescale_gap_a: assert property (@(posedge CLK) disable iff (!RSTN)
    tick && !ctrl_r.ext && ctrl_r.div != 3'h0 && !wr |=> !tick)
    else $error("prescale gap");
  // External clock: one synchronised rising edge gives exactly one count
  sequence ext_rise_s;
    ctrl_r.run && ctrl_r.ext && ek2_r && !ek3_r && !wr;
  endsequence
  sequence ext_settle_s;
    !tick;
  endsequence
  property ext_count_p;
    @(posedge CLK) disable iff (!RSTN)
      ext_rise_s |=> count_r == $past(count_r) + 16'h0001 ##0 ext_settle_s;
  endproperty
  ext_count_a: assert property (ext_count_p) else $error("ext count");
  // Transfer service request follows an overflow while the overflow interrupt enable is set
  io_service_a: assert property (@(posedge CLK) disable iff (!RSTN)
    wrap && ovie_r && !wr |=> IO_SERVICE_REQ) else $error("service req");
  // A write-one clear of the status overflow bit takes unless an overflow lands
  stat_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
    wr && lo_en && WB_ADR_I == STAT_OFS && WB_DAT_I[STAT_OVF_BIT] && !wrap
    |=> !stat_r[STAT_OVF_BIT]) else $error("status clear");
endmodule

// *** pin_source.sv ***
// Model of the external sources driving the capture and count clock pins
`timescale 1ns/1ps
module pin_source (
  // Clock
  input wire logic clk,
  // Pins
  output logic ext_clk,
  output logic [3:0] cap
);
  initial begin
    ext_clk = 1'b0;
    cap = 4'h0;
  end
  // Pins move just after an edge, as a real source would not care about phase
  task automatic drive(input logic [3:0] v);
    @(posedge clk);
    cap <= v;
  endtask
  // Each level is held past the two sync flops so no edge can be lost
  task automatic pulse();
    repeat (3) @(posedge clk);
    ext_clk <= 1'b1;
    repeat (3) @(posedge clk);
    ext_clk <= 1'b0;
  endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the free-running capture timer
`timescale 1ns/1ps
module tb;
  import frt_pkg::*;
  logic CLK, RSTN, cyc, stb, we, ack, irq, ovf_irq, svc, ext;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, dout;
  logic [3:0] cap_irq, cap;
  int err_count = 0;
  int compares = 0;
  int cyc_n = 0;
  frt_timer dut (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(dout), .WB_ACK_O(ack),
    .EXT_COUNT_CLOCK_PIN(ext), .CAPTURE_PIN(cap), .IRQ(irq), .OVF_IRQ(ovf_irq),
    .CAP_IRQ(cap_irq), .IO_SERVICE_REQ(svc));
  pin_source src (.clk(CLK), .ext_clk(ext), .cap(cap));
  // ===========================================
  // Common tasks
  always @(posedge CLK) cyc_n <= cyc_n + 1;
  task automatic give_verdict();
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Classic single cycle; read data is taken at the ack edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(nm, rdat, exp);
  endtask
  // ===========================================
  // Scenarios
  task automatic t_prescale();
    int c0, e;
    for (int d = 0; d < 8; d++) begin
      wr(COUNT_OFS, 32'h0);
      wr(CTRL_OFS, 32'h10 | d);
      c0 = cyc_n;
      repeat (6 << d) @(posedge CLK);
      wr(CTRL_OFS, 32'h0);
      e = (cyc_n - c0) >> d;
      bus(1'b0, COUNT_OFS, 32'h0);
      check("count_rate", 32'(rdat + 1 >= e && rdat <= e + 1), 32'h1);
    end
  endtask
  task automatic t_overflow();
    wr(MASK_OFS, 32'h1);
    wr(COUNT_OFS, 32'hfffd);
    wr(CTRL_OFS, 32'h90);
    repeat (8) @(posedge CLK);
    wr(CTRL_OFS, 32'hc0);
    check("ovf_irq", {29'h0, ovf_irq, svc, irq}, 32'h7);
    rd_chk("ctrl_ovf", CTRL_OFS, 32'hc0);
    rd_chk("stat_ovf", STAT_OFS, 32'h1);
    wr(MASK_OFS, 32'h0);
    @(posedge CLK);
    check("irq_mask", {30'h0, ovf_irq, irq}, 32'h2);
    wr(STAT_OFS, 32'h1);
    wr(CTRL_OFS, 32'h0);
    @(posedge CLK);
    check("ovf_clear", {30'h0, ovf_irq, svc}, 32'h0);
  endtask
  task automatic t_extclk();
    wr(COUNT_OFS, 32'h0);
    wr(CTRL_OFS, 32'h18);
    repeat (5) src.pulse();
    repeat (4) @(posedge CLK);
    rd_chk("ext_count", COUNT_OFS, 32'h5);
    wr(COUNT_OFS, 32'h77);
    rd_chk("load_running", COUNT_OFS, 32'h5);
    wr(CTRL_OFS, 32'h20);
    rd_chk("sw_clear", COUNT_OFS, 32'h0);
  endtask
  task automatic t_capture();
    logic [15:0] ex [4];
    ex = '{16'h1234, 16'h5678, 16'h5678, 16'h0000};
    wr(MASK_OFS, 32'h1e);
    // Channel 0 rising, 1 falling, 2 both, 3 none
    wr(EDGE_OFS, 32'h39);
    wr(COUNT_OFS, 32'h1234);
    src.drive(4'hf);
    repeat (5) @(posedge CLK);
    rd_chk("stat_rise", STAT_OFS, 32'h0a);
    check("cap_irq", {28'h0, cap_irq}, 32'h5);
    check("irq_cap", {31'h0, irq}, 32'h1);
    wr(STAT_OFS, 32'h1e);
    wr(COUNT_OFS, 32'h5678);
    src.drive(4'h0);
    repeat (5) @(posedge CLK);
    rd_chk("stat_fall", STAT_OFS, 32'h0c);
    for (int i = 0; i < 4; i++) begin
      rd_chk("cap_data", 6'(CAPT_OFS + 4 * i), {16'h0, ex[i]});
    end
  endtask
  // ===========================================
  // Main sequence
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    RSTN = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    wdat = 32'h0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rd_chk("count_rst", COUNT_OFS, 32'h0);
    rd_chk("ctrl_rst", CTRL_OFS, 32'h0);
    t_prescale();
    t_overflow();
    t_extclk();
    t_capture();
    wr(COUNT_OFS, 32'h77);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rd_chk("count_rst2", COUNT_OFS, 32'h0);
    give_verdict();
  end
endmodule
